/* tb_uirc_ctrl.sv */
`timescale 1ns/1ns
module tb_uirc_ctrl;
  import uirc_pkg::*;
  logic        sys_clk, rstn, reg_we, reg_re, prog_start, in_interrupt, cyclic_scan_start, unit_rw_strobe;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, cu_mounted, cu_busy, cu_unit_err, cu_setup_err, cu_cyclic_busy;
  logic [6:0]  unit_rw_num;
  logic [95:0] iu_mounted, iu_cyclic_busy, cyc_skip_mask;
  logic        redundant_mode, redundant_sync_ok, io_bus_fault, xfer_strobe, xfer_area, link_refresh_strobe;
  logic [15:0] xfer_addr, first_cio, first_dm, st;
  logic [3:0]  link_unit;
  logic        instr_error_flag, completion_ok_flag, cmd_done, int_task_error, deadline_miss, mclr;
  logic [7:0]  fault_after, cio_cnt, dm_cnt, link_cnt;
  int          mismatches, n_checks;

  ////////////////////////////////////////////////////////////////////////////
  // Design and far-side units
  uirc_ctrl #(.DEADLINE_CNT(200)) uirc_ctrl_i (.*);
  uirc_units_model uirc_units_model_i (.sys_clk(sys_clk), .rstn(rstn), .clr(mclr), .fault_after(fault_after),
    .xfer_strobe(xfer_strobe), .xfer_area(xfer_area), .xfer_addr(xfer_addr), .link_refresh_strobe(link_refresh_strobe),
    .io_bus_fault(io_bus_fault), .cio_cnt(cio_cnt), .dm_cnt(dm_cnt), .link_cnt(link_cnt),
    .first_cio(first_cio), .first_dm(first_dm));

  ////////////////////////////////////////////////////////////////////////////
  // Compare, bus and closing tasks
  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge sys_clk);
    reg_we <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge sys_clk);
    reg_re <= 1'b0;
    #1 st = reg_rdata;
  endtask
  task automatic pulse_rw_scan(input logic [6:0] n);
    @(posedge sys_clk);
    cyclic_scan_start <= 1'b1;
    @(posedge sys_clk);
    cyclic_scan_start <= 1'b0;
    unit_rw_strobe <= 1'b1;
    unit_rw_num <= n;
    @(posedge sys_clk);
    unit_rw_strobe <= 1'b0;
  endtask
  task automatic run_cmd(input logic kind, input logic [6:0] num, input logic exp_err, input logic exp_eq);
    int i;
    @(posedge sys_clk);
    mclr <= 1'b1;
    @(posedge sys_clk);
    mclr <= 1'b0;
    reg_wr(REG_CMD, {1'b1, kind, 7'h00, num});
    for (i = 0; i < 400 && cmd_done !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (cmd_done !== 1'b1) begin
      mismatches++;
      $display("ERROR at %0t: command never completed", $time);
      finish_test();
    end
    chk_bit(instr_error_flag, exp_err, "error flag");
    chk_bit(completion_ok_flag, exp_eq, "completion flag");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic sc_numbers();
    run_cmd(KIND_IU, 7'd95, 1'b0, 1'b1);
    run_cmd(KIND_IU, 7'd96, 1'b1, 1'b0);
    run_cmd(KIND_CU, 7'd15, 1'b0, 1'b1);
    run_cmd(KIND_CU, 7'd16, 1'b1, 1'b0);
    run_cmd(KIND_IU, 7'd3, 1'b1, 1'b0);
    run_cmd(KIND_CU, 7'd4, 1'b1, 1'b0);
  endtask
  task automatic sc_transfer(input logic kind, input logic [6:0] n);
    run_cmd(kind, n, 1'b0, 1'b1);
    chk_word({8'h00, cio_cnt}, kind ? CU_CIO_WORDS : IU_CIO_WORDS, "core words");
    chk_word({8'h00, dm_cnt}, kind ? CU_DM_WORDS : IU_DM_WORDS, "data words");
    chk_word(first_cio, kind ? CU_CIO_BASE + n * CU_CIO_WORDS : IU_CIO_BASE + n * IU_CIO_WORDS,
      "core base");
    chk_word(first_dm, kind ? CU_DM_BASE + n * CU_DM_WORDS : IU_DM_BASE + n * IU_DM_WORDS, "data base");
    chk_word({8'h00, link_cnt}, {15'h0000, kind}, "unit image refresh");
    chk_word({12'h000, link_unit}, {12'h000, n[3:0]}, "image unit");
  endtask
  task automatic sc_skips();
    for (int k = 0; k < 6; k++) begin
      @(posedge sys_clk);
      iu_cyclic_busy[7] <= k == 0;
      cu_busy[3] <= k == 1;
      cu_unit_err[3] <= k == 2;
      cu_setup_err[3] <= k == 3;
      in_interrupt <= k == 4;
      cu_cyclic_busy[3] <= k >= 4;
      run_cmd(k ? KIND_CU : KIND_IU, k ? 7'd3 : 7'd7, 1'b0, k == 5);
      chk_word({cio_cnt, dm_cnt}, k == 5 ? 16'h1964 : 16'h0000, "skipped words");
    end
    @(posedge sys_clk);
    iu_cyclic_busy <= '0;
    in_interrupt <= 1'b0;
    cu_cyclic_busy <= '0;
    redundant_mode <= 1'b1;
    run_cmd(KIND_CU, 7'd3, 1'b1, 1'b0);
    redundant_sync_ok <= 1'b1;
    run_cmd(KIND_CU, 7'd3, 1'b0, 1'b1);
  endtask
  task automatic sc_fault();
    fault_after <= 8'd20;
    run_cmd(KIND_IU, 7'd5, 1'b0, 1'b0);
    chk_bit(dm_cnt < 8'd100, 1'b1, "words after fault");
    run_cmd(KIND_CU, 7'd2, 1'b0, 1'b0);
    chk_bit(dm_cnt < 8'd100, 1'b1, "words after fault");
    fault_after <= 8'd0;
  endtask
  task automatic sc_duplicate();
    reg_wr(REG_STATUS, 16'h0038);
    #1 chk_bit(int_task_error, 1'b0, "task error cleared");
    pulse_rw_scan(7'd5);
    run_cmd(KIND_IU, 7'd5, 1'b0, 1'b1);
    reg_rd(REG_STATUS);
    chk_bit(st[ST_DUP], 1'b1, "duplicate bit");
    chk_bit(int_task_error, 1'b1, "task error");
    reg_wr(REG_STATUS, 16'h0038);
    @(posedge sys_clk);
    unit_rw_strobe <= 1'b1;
    @(posedge sys_clk);
    unit_rw_strobe <= 1'b0;
    #1 chk_bit(int_task_error, 1'b1, "rw duplicate");
    reg_wr(REG_STATUS, 16'h0038);
    reg_wr(REG_DIS_BASE, 16'h0020);
    reg_wr(REG_DIS_BASE + 4'h1, 16'h0002);
    reg_rd(REG_DIS_BASE);
    chk_word(st, 16'h0020, "disable word");
    chk_bit(cyc_skip_mask[5], 1'b1, "cyclic skip");
    reg_rd(4'hf);
    chk_word(st, 16'h0000, "unmapped read");
    pulse_rw_scan(7'd5);
    in_interrupt <= 1'b1;
    run_cmd(KIND_IU, 7'd5, 1'b0, 1'b1);
    in_interrupt <= 1'b0;
    reg_rd(REG_STATUS);
    chk_bit(st[ST_DUP], 1'b0, "no duplicate when disabled");
  endtask
  task automatic sc_deadline();
    @(posedge sys_clk);
    prog_start <= 1'b1;
    @(posedge sys_clk);
    prog_start <= 1'b0;
    repeat (150) @(posedge sys_clk);
    #1 chk_bit(deadline_miss, 1'b0, "deadline early");
    repeat (100) @(posedge sys_clk);
    #1 chk_bit(deadline_miss, 1'b1, "deadline missed");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Main sequence
  initial begin
    {rstn, reg_we, reg_re, prog_start, in_interrupt, cyclic_scan_start, unit_rw_strobe, mclr} = '0;
    {reg_addr, reg_wdata, unit_rw_num, fault_after, redundant_mode, redundant_sync_ok} = '0;
    {iu_cyclic_busy, cu_busy, cu_unit_err, cu_setup_err, cu_cyclic_busy} = '0;
    iu_mounted = (96'h1 << 95) | (96'h1 << 17) | 96'ha0;
    cu_mounted = 16'h800c;
    mismatches = 0;
    n_checks = 0;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    #1 chk_bit(deadline_miss, 1'b0, "deadline at reset");
    sc_numbers();
    sc_transfer(KIND_IU, 7'd5);
    sc_transfer(KIND_CU, 7'd2);
    sc_skips();
    sc_fault();
    sc_duplicate();
    sc_deadline();
    finish_test();
  end
endmodule // tb_uirc_ctrl

/* uirc_ctrl.sv */
// Functional notes
// - Intelligent unit numbers 0..95, else error
// - Error if intelligent unit absent, else clear
// - Completion set; cleared if cyclic busy
// - Exchange core-I/O and data-memory words together
// - Word range derived from unit number
// - Disabled units skipped by cyclic refresh
// - Duplicate refresh raises interrupt-task error
// - Disabled units refreshed within 11 seconds
// - Intelligent transfer stops on bus fault
// - Communication unit numbers 0..15, else error
// - Error if communication unit absent, else clear
// - Redundant CPUs out of sync sets error
// - Busy communication unit: skip, clear completion
// - Unit or setup error: skip, clear completion
// - Interrupt overlap with cyclic clears completion
// - Exchange 25 core-I/O and 100 data words
// - Also refresh unit's link or remote image
// - Communication transfer stops on bus fault
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
module uirc_ctrl #(
  parameter int DEADLINE_CNT = uirc_pkg::DEADLINE_CYCLES
) (
  // Clock and reset
  input  wire logic                           sys_clk,
  input  wire logic                           rstn,
  // Register port
  input  wire logic [3:0]                     reg_addr,
  input  wire logic [15:0]                    reg_wdata,
  input  wire logic                           reg_we,
  input  wire logic                           reg_re,
  output logic [15:0]                         reg_rdata,
  // Program executor context
  input  wire logic                           prog_start,
  input  wire logic                           in_interrupt,
  input  wire logic                           cyclic_scan_start,
  input  wire logic                           unit_rw_strobe,
  input  wire logic [6:0]                     unit_rw_num,
  // Intelligent unit status
  input  wire logic [uirc_pkg::IU_UNITS-1:0]  iu_mounted,
  input  wire logic [uirc_pkg::IU_UNITS-1:0]  iu_cyclic_busy,
  // Communication unit status
  input  wire logic [uirc_pkg::CU_UNITS-1:0]  cu_mounted,
  input  wire logic [uirc_pkg::CU_UNITS-1:0]  cu_busy,
  input  wire logic [uirc_pkg::CU_UNITS-1:0]  cu_unit_err,
  input  wire logic [uirc_pkg::CU_UNITS-1:0]  cu_setup_err,
  input  wire logic [uirc_pkg::CU_UNITS-1:0]  cu_cyclic_busy,
  input  wire logic                           redundant_mode,
  input  wire logic                           redundant_sync_ok,
  // I/O bus transfer
  input  wire logic                           io_bus_fault,
  output logic                                xfer_strobe,
  output logic                                xfer_area,
  output logic [15:0]                         xfer_addr,
  output logic                                link_refresh_strobe,
  output logic [3:0]                          link_unit,
  // Results
  output logic                                instr_error_flag,
  output logic                                completion_ok_flag,
  output logic                                cmd_done,
  output logic [uirc_pkg::IU_UNITS-1:0]       cyc_skip_mask,
  output logic                                int_task_error,
  output logic                                deadline_miss
);
  import uirc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  uirc_state_t             state;
  logic                    kind;
  logic [15:0]             unit_num;
  logic [15:0]             word_cnt;
  logic [15:0]             cio_base;
  logic [15:0]             dm_base;
  logic [IU_UNITS-1:0]     cyc_dis;
  logic [IU_UNITS-1:0]     touched;
  logic [IU_UNITS-1:0]     refreshed;
  logic [31:0]             dl_cnt;
  logic                    dl_run;
  logic                    dl_hit;
  logic                    dup_flag;
  logic                    dup_evt;
  logic                    rw_dup;
  logic                    chk_dup;
  logic                    st_clr;
  logic                    start_cmd;
  logic [6:0]              iu_idx;
  logic [3:0]              cu_idx;
  logic                    chk_err;
  logic                    chk_skip;
  logic                    iu_done;
  logic [15:0]             cio_last;
  logic [15:0]             dm_last;

  assign iu_idx    = unit_num[CMD_NUM_MSB:0];
  assign cu_idx    = unit_num[3:0];
  assign start_cmd = reg_we && (reg_addr == REG_CMD) && reg_wdata[CMD_START_BIT] && (state == UIRC_IDLE);
  assign st_clr    = reg_we && (reg_addr == REG_STATUS);
  assign cio_last  = (kind == KIND_IU) ? IU_CIO_WORDS - 16'h0001 : CU_CIO_WORDS - 16'h0001;
  assign dm_last   = (kind == KIND_IU) ? IU_DM_WORDS - 16'h0001 : CU_DM_WORDS - 16'h0001;
  assign cyc_skip_mask = cyc_dis;

  ////////////////////////////////////////////////////////////////////////////
  // Command validation
  always_comb begin
    chk_err  = 1'b0;
    chk_skip = 1'b0;
    chk_dup  = 1'b0;
    if (kind == KIND_IU) begin
      if (unit_num > IU_MAX_NUM) begin
        chk_err = 1'b1;
      end else if (!iu_mounted[iu_idx]) begin
        chk_err = 1'b1;
      end else begin
        chk_skip = iu_cyclic_busy[iu_idx];
        chk_dup  = !cyc_dis[iu_idx] && touched[iu_idx];
      end
    end else begin
      if (unit_num > CU_MAX_NUM) begin
        chk_err = 1'b1;
      end else if (!cu_mounted[cu_idx]) begin
        chk_err = 1'b1;
      end else if (redundant_mode && !redundant_sync_ok) begin
        chk_err = 1'b1;
      end else begin
        chk_skip = cu_busy[cu_idx]
                 || cu_unit_err[cu_idx] || cu_setup_err[cu_idx]
                 || (in_interrupt && cu_cyclic_busy[cu_idx]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command capture and unit word bases
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      kind     <= KIND_IU;
      unit_num <= 16'h0000;
    end else if (start_cmd) begin
      kind     <= reg_wdata[CMD_KIND_BIT];
      unit_num <= {9'h000, reg_wdata[CMD_NUM_MSB:0]};
    end
  end

  // Allocated words found from the command kind and unit number
  always_comb begin
    if (kind == KIND_IU) begin
      cio_base = 16'(IU_CIO_BASE + unit_num * IU_CIO_WORDS);
      dm_base  = 16'(IU_DM_BASE + unit_num * IU_DM_WORDS);
    end else begin
      cio_base = 16'(CU_CIO_BASE + unit_num * CU_CIO_WORDS);
      dm_base  = 16'(CU_DM_BASE + unit_num * CU_DM_WORDS);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state    <= UIRC_IDLE;
      word_cnt <= 16'h0000;
    end else begin
      unique case (state)
        UIRC_IDLE: begin
          word_cnt <= 16'h0000;
          if (start_cmd) begin
            state <= UIRC_CHECK;
          end
        end
        UIRC_CHECK: begin
          state <= (chk_err || chk_skip) ? UIRC_FINISH : UIRC_CIO;
        end
        UIRC_CIO: begin
          if (io_bus_fault) begin
            state <= UIRC_FINISH;
          end else if (word_cnt == cio_last) begin
            word_cnt <= 16'h0000;
            state    <= UIRC_DM;
          end else begin
            word_cnt <= word_cnt + 16'h0001;
          end
        end
        UIRC_DM: begin
          if (io_bus_fault) begin
            state <= UIRC_FINISH;
          end else if (word_cnt == dm_last) begin
            word_cnt <= 16'h0000;
            state    <= (kind == KIND_CU) ? UIRC_LINK : UIRC_FINISH;
          end else begin
            word_cnt <= word_cnt + 16'h0001;
          end
        end
        UIRC_LINK: begin
          state <= UIRC_FINISH;
        end
        UIRC_FINISH: begin
          state <= UIRC_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word exchange strobes toward the I/O bus
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      xfer_strobe         <= 1'b0;
      xfer_area           <= AREA_CIO;
      xfer_addr           <= 16'h0000;
      link_refresh_strobe <= 1'b0;
      link_unit           <= 4'h0;
    end else begin
      xfer_strobe         <= ((state == UIRC_CIO) || (state == UIRC_DM)) && !io_bus_fault;
      xfer_area           <= (state == UIRC_DM) ? AREA_DM : AREA_CIO;
      xfer_addr           <= (state == UIRC_DM) ? dm_base + word_cnt : cio_base + word_cnt;
      link_refresh_strobe <= (state == UIRC_LINK);
      link_unit           <= cu_idx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result flags, written once per execution
  logic fault_seen;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fault_seen <= 1'b0;
    end else if (state == UIRC_CHECK) begin
      fault_seen <= 1'b0;
    end else if (((state == UIRC_CIO) || (state == UIRC_DM)) && io_bus_fault) begin
      fault_seen <= 1'b1;
    end
  end

  logic res_err;
  logic res_skip;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      res_err  <= 1'b0;
      res_skip <= 1'b0;
    end else if (state == UIRC_CHECK) begin
      res_err  <= chk_err;
      res_skip <= chk_skip;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      instr_error_flag   <= 1'b0;
      completion_ok_flag <= 1'b0;
      cmd_done           <= 1'b0;
    end else begin
      cmd_done <= (state == UIRC_FINISH);
      if (state == UIRC_FINISH) begin
        instr_error_flag   <= res_err;
        completion_ok_flag <= !res_err && !res_skip && !fault_seen;
      end
    end
  end

  assign iu_done = (state == UIRC_FINISH) && (kind == KIND_IU) && !res_err && !res_skip && !fault_seen;

  ////////////////////////////////////////////////////////////////////////////
  // Cyclic refresh disable settings
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cyc_dis <= '0;
    end else begin
      for (int i = 0; i < DIS_REGS; i++) begin
        if (reg_we && (reg_addr == REG_DIS_BASE + 4'(i))) begin
          cyc_dis[i*16 +: 16] <= reg_wdata;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-unit touch tracking for duplicate detection and deadline
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      touched   <= '0;
      refreshed <= '0;
    end else begin
      for (int i = 0; i < IU_UNITS; i++) begin
        if ((iu_done && iu_idx == 7'(i)) || (unit_rw_strobe && unit_rw_num == 7'(i))) begin
          touched[i] <= 1'b1;
        end else if (cyclic_scan_start) begin
          touched[i] <= 1'b0;
        end
        if (iu_done && iu_idx == 7'(i)) begin
          refreshed[i] <= 1'b1;
        end else if (prog_start) begin
          refreshed[i] <= 1'b0;
        end
      end
    end
  end

  assign rw_dup  = unit_rw_strobe && (unit_rw_num < 7'(IU_UNITS))
                 && !cyc_dis[unit_rw_num] && touched[unit_rw_num];
  assign dup_evt = ((state == UIRC_CHECK) && (kind == KIND_IU) && !chk_err && chk_dup) || rw_dup;

  // Program-start deadline counter
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dl_cnt <= 32'h0000_0000;
      dl_run <= 1'b0;
    end else if (prog_start) begin
      dl_cnt <= 32'h0000_0000;
      dl_run <= 1'b1;
    end else if (dl_run) begin
      if (dl_cnt == 32'(DEADLINE_CNT - 1)) begin
        dl_run <= 1'b0;
      end
      dl_cnt <= dl_cnt + 32'h0000_0001;
    end
  end

  assign dl_hit = dl_run && (dl_cnt == 32'(DEADLINE_CNT - 1))
                && |(cyc_dis & iu_mounted & ~refreshed);

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status flags, write one to clear
  uirc_sticky u_dup (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .set_evt (dup_evt),
    .clr_evt (st_clr && reg_wdata[ST_DUP]),
    .flag    (dup_flag)
  );

  uirc_sticky u_iterr (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .set_evt (dup_evt),
    .clr_evt (st_clr && reg_wdata[ST_ITERR]),
    .flag    (int_task_error)
  );

  uirc_sticky u_miss (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .set_evt (dl_hit),
    .clr_evt (st_clr && reg_wdata[ST_MISS]),
    .flag    (deadline_miss)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register read path, data one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_re) begin
      reg_rdata <= 16'h0000;
      if (reg_addr == REG_CMD) begin
        reg_rdata <= {1'b0, kind, 7'h00, iu_idx};
      end else if (reg_addr == REG_STATUS) begin
        reg_rdata[ST_BUSY]  <= (state != UIRC_IDLE);
        reg_rdata[ST_ERR]   <= instr_error_flag;
        reg_rdata[ST_EQ]    <= completion_ok_flag;
        reg_rdata[ST_DUP]   <= dup_flag;
        reg_rdata[ST_ITERR] <= int_task_error;
        reg_rdata[ST_MISS]  <= deadline_miss;
      end else begin
        for (int i = 0; i < DIS_REGS; i++) begin
          if (reg_addr == REG_DIS_BASE + 4'(i)) begin
            reg_rdata <= cyc_dis[i*16 +: 16];
          end
        end
      end
    end
  end

endmodule // uirc_ctrl

/* uirc_ctrl_props.sv */
`timescale 1ns/1ns
module uirc_ctrl_props #(
  parameter int DEADLINE_CNT = 200
) (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rstn,
  // Register port
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_we,
  // Transfer side
  input wire logic        io_bus_fault,
  input wire logic        xfer_strobe,
  input wire logic        xfer_area,
  input wire logic [15:0] xfer_addr,
  input wire logic        link_refresh_strobe,
  // Results
  input wire logic        instr_error_flag,
  input wire logic        completion_ok_flag,
  input wire logic        cmd_done
);
  import uirc_pkg::*;
  logic       busy_h;
  logic       kind_h;
  logic [7:0] words;
  logic [1:0] links;
  wire start_w = reg_we && reg_addr == REG_CMD && reg_wdata[CMD_START_BIT];
  wire acc_w   = start_w && (!busy_h || cmd_done);
  wire bad_w   = reg_wdata[CMD_KIND_BIT] ? reg_wdata[6:0] > 7'd15 : reg_wdata[6:0] > 7'd95;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////////////
  // Command tracking and word counting
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      busy_h <= 1'b0;
      kind_h <= 1'b0;
      words  <= 8'h00;
      links  <= 2'h0;
    end else if (acc_w) begin
      busy_h <= 1'b1;
      kind_h <= reg_wdata[CMD_KIND_BIT];
      words  <= 8'h00;
      links  <= 2'h0;
    end else begin
      if (cmd_done) busy_h <= 1'b0;
      if (xfer_strobe) words <= words + 8'h01;
      if (link_refresh_strobe) links <= links + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_done_one_pulse: assert property (cmd_done |=> !cmd_done) else $error("done pulse too long");
  a_flags_hold: assert property (!cmd_done
    |-> $stable(instr_error_flag) && $stable(completion_ok_flag)) else $error("flags moved without completion");
  a_range_error: assert property (acc_w && bad_w |-> ##3 cmd_done && instr_error_flag)
    else $error("bad unit number not flagged");
  a_err_no_work: assert property (cmd_done && instr_error_flag
    |-> words == 8'h00 && !completion_ok_flag) else $error("error command moved words");
  a_ok_word_count: assert property (cmd_done && completion_ok_flag
    |-> words == (kind_h ? 8'd125 : 8'd110)) else $error("wrong word count");
  a_link_once: assert property (cmd_done && completion_ok_flag |-> links == {1'b0, kind_h})
    else $error("unit image refresh count wrong");
  a_addr_step: assert property (xfer_strobe && $past(xfer_strobe) && xfer_area == $past(xfer_area)
    |-> xfer_addr == $past(xfer_addr) + 16'h0001) else $error("word address not consecutive");
  a_fault_stop: assert property (busy_h && io_bus_fault && xfer_strobe
    |-> ##[1:4] cmd_done && !completion_ok_flag) else $error("transfer not stopped on bus fault");
  c_iu_ok: cover property (cmd_done && completion_ok_flag && !kind_h);
  c_cu_ok: cover property (cmd_done && completion_ok_flag && kind_h);
  c_err: cover property (cmd_done && instr_error_flag);
endmodule // uirc_ctrl_props

bind uirc_ctrl uirc_ctrl_props #(.DEADLINE_CNT(DEADLINE_CNT)) uirc_ctrl_props_i (
  .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
  .io_bus_fault(io_bus_fault), .xfer_strobe(xfer_strobe), .xfer_area(xfer_area), .xfer_addr(xfer_addr),
  .link_refresh_strobe(link_refresh_strobe), .instr_error_flag(instr_error_flag),
  .completion_ok_flag(completion_ok_flag), .cmd_done(cmd_done)
);

/* uirc_pkg.sv */
package uirc_pkg;

  // Register indices on the plain register port
  localparam logic [3:0] REG_CMD      = 4'h0;
  localparam logic [3:0] REG_STATUS   = 4'h1;
  localparam logic [3:0] REG_DIS_BASE = 4'h2;
  localparam int         DIS_REGS     = 6;

  // Command register fields
  localparam int CMD_START_BIT = 15;
  localparam int CMD_KIND_BIT  = 14;
  localparam int CMD_NUM_MSB   = 6;

  // Status register fields
  localparam int ST_BUSY  = 0;
  localparam int ST_ERR   = 1;
  localparam int ST_EQ    = 2;
  localparam int ST_DUP   = 3;
  localparam int ST_ITERR = 4;
  localparam int ST_MISS  = 5;

  // Unit number ranges
  localparam int         IU_UNITS  = 96;
  localparam int         CU_UNITS  = 16;
  localparam logic [15:0] IU_MAX_NUM = 16'h005f;
  localparam logic [15:0] CU_MAX_NUM = 16'h000f;

  // Word layout of each unit's allocated areas
  localparam logic [15:0] IU_CIO_BASE  = 16'h07d0;
  localparam logic [15:0] IU_CIO_WORDS = 16'h000a;
  localparam logic [15:0] IU_DM_BASE   = 16'h4e20;
  localparam logic [15:0] IU_DM_WORDS  = 16'h0064;
  localparam logic [15:0] CU_CIO_BASE  = 16'h0578;
  localparam logic [15:0] CU_CIO_WORDS = 16'h0019;
  localparam logic [15:0] CU_DM_BASE   = 16'h7530;
  localparam logic [15:0] CU_DM_WORDS  = 16'h0064;

  // Start-of-program refresh deadline
  localparam int DEADLINE_S     = 11;
  localparam int CLK_HZ         = 20_000_000;
  localparam int DEADLINE_CYCLES = DEADLINE_S * CLK_HZ;

  // Command kinds and transfer areas
  localparam logic KIND_IU   = 1'b0;
  localparam logic KIND_CU   = 1'b1;
  localparam logic AREA_CIO  = 1'b0;
  localparam logic AREA_DM   = 1'b1;

  typedef enum logic [2:0] {
    UIRC_IDLE,
    UIRC_CHECK,
    UIRC_CIO,
    UIRC_DM,
    UIRC_LINK,
    UIRC_FINISH
  } uirc_state_t;

endpackage

/* uirc_sticky.sv */
`timescale 1ns/1ns
module uirc_sticky (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // Set and clear
  input  wire logic set_evt,
  input  wire logic clr_evt,
  // Flag
  output logic      flag
);

  // Set wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flag <= 1'b0;
    end else if (set_evt) begin
      flag <= 1'b1;
    end else if (clr_evt) begin
      flag <= 1'b0;
    end
  end

endmodule // uirc_sticky

/* uirc_units_model.sv */
`timescale 1ns/1ns
module uirc_units_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // Bench control
  input  wire logic        clr,
  input  wire logic [7:0]  fault_after,
  // Transfer side
  input  wire logic        xfer_strobe,
  input  wire logic        xfer_area,
  input  wire logic [15:0] xfer_addr,
  input  wire logic        link_refresh_strobe,
  output logic             io_bus_fault,
  // Observed counts
  output logic [7:0]       cio_cnt,
  output logic [7:0]       dm_cnt,
  output logic [7:0]       link_cnt,
  output logic [15:0]      first_cio,
  output logic [15:0]      first_dm
);
  import uirc_pkg::*;

  // Bus fault once the chosen number of words has passed
  assign io_bus_fault = fault_after != 8'h00 && ({1'b0, cio_cnt} + {1'b0, dm_cnt}) >= {1'b0, fault_after};

  // Word and image counters of the attached unit
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn || clr) begin
      cio_cnt   <= 8'h00;
      dm_cnt    <= 8'h00;
      link_cnt  <= 8'h00;
      first_cio <= 16'h0000;
      first_dm  <= 16'h0000;
    end else begin
      if (link_refresh_strobe) link_cnt <= link_cnt + 8'h01;
      if (xfer_strobe && xfer_area == AREA_DM) begin
        if (dm_cnt == 8'h00) first_dm <= xfer_addr;
        dm_cnt <= dm_cnt + 8'h01;
      end else if (xfer_strobe) begin
        if (cio_cnt == 8'h00) first_cio <= xfer_addr;
        cio_cnt <= cio_cnt + 8'h01;
      end
    end
  end
endmodule // uirc_units_model
